//--- rtl/fnd_pkg.sv
// Shared constants and carrier types of the fractional-N divider core
package fnd_pkg;
	// Register bus
	localparam int FND_ADDR_W = 8;
	localparam logic [7:0] FND_MAIN_OFS = 8'h00;
	localparam logic [7:0] FND_FRAC_OFS = 8'h04;
	localparam logic [7:0] FND_AUX_OFS = 8'h08;
	localparam logic [7:0] FND_REF_OFS = 8'h0c;
	localparam logic [7:0] FND_STAT_OFS = 8'h10;
	localparam logic [1:0] FND_RESP_OKAY = 2'h0;
	localparam logic [1:0] FND_RESP_SLVERR = 2'h2;

	// Field positions
	localparam int FND_AUX_PRE_LSB = 0;
	localparam int FND_AUX_PRE_W = 4;
	localparam int FND_AUX_CNT_LSB = 4;
	localparam int FND_AUX_CNT_W = 12;
	localparam int FND_REF_RATIO_LSB = 0;
	localparam int FND_REF_RATIO_W = 10;
	localparam int FND_MTAP_LSB = 10;
	localparam int FND_ATAP_LSB = 13;

	// Reset values
	localparam logic [15:0] FND_MAIN_RST = 16'h0200;
	localparam logic [6:0] FND_FRAC_RST = 7'h00;
	localparam logic [15:0] FND_AUX_RST = 16'h0107;
	localparam logic [15:0] FND_REF_RST = 16'h0004;

	// Fraction moduli
	localparam logic [3:0] FND_MOD_FIVE = 4'h5;
	localparam logic [3:0] FND_MOD_EIGHT = 4'h8;

	// Backlash time
	localparam int FND_CLK_PERIOD_NS = 25;
	localparam int FND_BACKLASH_NS = 50;
	localparam int FND_BACKLASH_CYC = (FND_BACKLASH_NS + FND_CLK_PERIOD_NS - 1) / FND_CLK_PERIOD_NS;

	typedef struct packed {
		logic power_down;
		logic pump_gain_bit1;
		logic pump_gain_bit0;
		logic fraction_modulus_select;
		logic [2:0] fractional_increment;
	} fnd_frac_cfg_t;

	typedef struct packed {
		logic up;
		logic dn;
	} fnd_pump_t;
endpackage

//--- rtl/fnd_core.sv
// Fractional-N main, auxiliary and reference dividers with phase detectors and AXI4-Lite registers
//
// Function
// - The main divider ratio can be set anywhere from 512 to 65536 VCO cycles.
// - Each completed main divider cycle gives one feedback pulse to the main phase detector.
// - At each main divider cycle end the accumulator adds the fractional increment.
// - The accumulator wraps at modulus 5 or 8 chosen by the modulus select bit.
// - Modulus select 1 picks modulus 5 and 0 picks modulus 8.
// - On accumulator overflow the next main cycle divides by N+1.
// - The accumulator contents are presented on an output for the compensation pump.
// - A new main ratio is taken only at a main divider cycle boundary.
// - The auxiliary input drives a prescaler followed by a counter feeding the aux detector.
// - The reference divider divides by 4 to 1023 and drives a three-bit counter.
// - Main and aux three-bit tap selects pick one of four reference counter pulses.
// - Each phase detector compares its reference and divider pulses and drives up and down.
// - Two pump gain bits from a control word set the pump current selection.
// - Pump gain bit 1 disables the integral pump while the proportional pump stays on.
// - Every comparison holds both pump controls on for a minimum backlash time.
// - Leaving power-down restarts main and reference dividers together.
//
// The placing of the registers and the AXI4-Lite slave port were left to the implementer.
`timescale 1ns/1ps
module fnd_core #(
	parameter int BACKLASH_CYC_P = fnd_pkg::FND_BACKLASH_CYC
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// Divider inputs from pins
	input wire logic vco_input,
	input wire logic aux_input,
	input wire logic ref_input,
	// AXI4-Lite write
	input wire logic [fnd_pkg::FND_ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read
	input wire logic [fnd_pkg::FND_ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Pump controls and compensation
	output fnd_pkg::fnd_pump_t main_prop_pump,
	output fnd_pkg::fnd_pump_t main_int_pump,
	output fnd_pkg::fnd_pump_t aux_pump,
	output logic [1:0] pump_gain,
	output logic [2:0] frac_acc,
	output logic main_fb_pulse
);
	import fnd_pkg::*;

	if (BACKLASH_CYC_P < 1 || BACKLASH_CYC_P > 15) begin : g_bad_backlash
		$error("BACKLASH_CYC_P must lie in 1..15");
	end

	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
		merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
	endfunction

	function automatic logic [16:0] ratio_of(input logic [15:0] r);
		ratio_of = (r == 16'h0000) ? 17'h10000 : {1'b0, r};
	endfunction

	function automatic logic tap_hit(input logic [2:0] sel, input logic [2:0] cnt, input logic tick);
		unique case (sel)
			3'h0: tap_hit = tick;
			3'h1: tap_hit = tick && cnt[0];
			3'h2: tap_hit = tick && (cnt[1:0] == 2'h3);
			3'h3: tap_hit = tick && (cnt == 3'h7);
			default: tap_hit = 1'b0;
		endcase
	endfunction

	// Registers
	logic [15:0] main_ratio_q;
	fnd_frac_cfg_t frac_cfg_q;
	logic [15:0] aux_cfg_q;
	logic [15:0] ref_cfg_q;

	// Bus state
	logic [FND_ADDR_W-1:0] aw_addr_q;
	logic [31:0] w_data_q;
	logic [3:0] w_strb_q;
	logic aw_hit, ar_hit, do_write;
	logic [31:0] rd_d;

	// Pin synchronisers: vco, aux, ref
	logic [2:0] pin_meta_q, pin_sync_q, pin_last_q;
	logic [2:0] pin_edge;

	always_ff @(posedge mclk) begin
		if (rst) begin
			pin_meta_q <= 3'h0;
			pin_sync_q <= 3'h0;
			pin_last_q <= 3'h0;
		end else begin
			pin_meta_q <= {ref_input, aux_input, vco_input};
			pin_sync_q <= pin_meta_q;
			pin_last_q <= pin_sync_q;
		end
	end
	assign pin_edge = pin_sync_q & ~pin_last_q;

	// AXI4-Lite slave: address and data taken in either order, one cycle to response
	assign do_write = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
	assign aw_hit = (aw_addr_q == FND_MAIN_OFS) || (aw_addr_q == FND_FRAC_OFS) ||
		(aw_addr_q == FND_AUX_OFS) || (aw_addr_q == FND_REF_OFS);

	always_ff @(posedge mclk) begin
		if (rst) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= FND_RESP_OKAY;
			aw_addr_q <= '0;
			w_data_q <= 32'h0;
			w_strb_q <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				s_axi_awready <= 1'b0;
				aw_addr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				s_axi_wready <= 1'b0;
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
			end
			if (do_write) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= aw_hit ? FND_RESP_OKAY : FND_RESP_SLVERR;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			main_ratio_q <= FND_MAIN_RST;
			frac_cfg_q <= FND_FRAC_RST;
			aux_cfg_q <= FND_AUX_RST;
			ref_cfg_q <= FND_REF_RST;
		end else if (do_write) begin
			unique case (aw_addr_q)
				FND_MAIN_OFS: main_ratio_q <= merge16(main_ratio_q, w_data_q, w_strb_q);
				FND_FRAC_OFS: if (w_strb_q[0]) frac_cfg_q <= w_data_q[6:0];
				FND_AUX_OFS: aux_cfg_q <= merge16(aux_cfg_q, w_data_q, w_strb_q);
				FND_REF_OFS: ref_cfg_q <= merge16(ref_cfg_q, w_data_q, w_strb_q);
				default: ;
			endcase
		end
	end

	// Main divider with fractional accumulator
	logic [16:0] main_cnt_q;
	logic [15:0] n_cur_q;
	logic [2:0] acc_q;
	logic fb_pulse_q;
	logic pd_last_q;
	logic [3:0] modulus, acc_sum;
	logic acc_ovf, main_end;
	logic [2:0] acc_d;
	logic [2:0] acc_base;

	// A modulus change can leave the accumulator at or above the new modulus; restart it from zero then
	assign acc_base = ({1'b0, acc_q} >= modulus) ? 3'h0 : acc_q;

	assign modulus = frac_cfg_q.fraction_modulus_select ? FND_MOD_FIVE : FND_MOD_EIGHT;
	assign acc_sum = {1'b0, acc_base} + {1'b0, frac_cfg_q.fractional_increment};
	assign acc_ovf = acc_sum >= modulus;
	assign acc_d = acc_ovf ? 3'(acc_sum - modulus) : acc_sum[2:0];
	assign main_end = pin_edge[0] && (main_cnt_q == 17'h00001);

	always_ff @(posedge mclk) begin
		if (rst) begin
			pd_last_q <= 1'b0;
		end else begin
			pd_last_q <= frac_cfg_q.power_down;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst || frac_cfg_q.power_down) begin
			main_cnt_q <= ratio_of(main_ratio_q);
			n_cur_q <= main_ratio_q;
			acc_q <= 3'h0;
		end else if (main_end) begin
			n_cur_q <= main_ratio_q;
			acc_q <= acc_d;
			main_cnt_q <= ratio_of(main_ratio_q) + {16'h0000, acc_ovf};
		end else begin
			if (pin_edge[0]) begin
				main_cnt_q <= main_cnt_q - 17'h00001;
			end
			acc_q <= acc_base;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			fb_pulse_q <= 1'b0;
		end else begin
			fb_pulse_q <= main_end;
		end
	end

	// Auxiliary divider: prescaler then counter
	logic [FND_AUX_PRE_W-1:0] pre_cnt_q;
	logic [FND_AUX_CNT_W-1:0] aux_cnt_q;
	logic aux_pulse_q, pre_tick, aux_end;

	assign pre_tick = pin_edge[1] && (pre_cnt_q == '0);
	assign aux_end = pre_tick && (aux_cnt_q <= FND_AUX_CNT_W'(1));

	always_ff @(posedge mclk) begin
		if (rst) begin
			pre_cnt_q <= '0;
			aux_cnt_q <= '0;
			aux_pulse_q <= 1'b0;
		end else begin
			aux_pulse_q <= aux_end;
			if (pin_edge[1]) begin
				pre_cnt_q <= pre_tick ? aux_cfg_q[FND_AUX_PRE_LSB +: FND_AUX_PRE_W] : pre_cnt_q - 1'b1;
			end
			if (pre_tick) begin
				aux_cnt_q <= aux_end ? aux_cfg_q[FND_AUX_CNT_LSB +: FND_AUX_CNT_W] : aux_cnt_q - 1'b1;
			end
		end
	end

	// Reference divider and three-bit counter
	logic [FND_REF_RATIO_W-1:0] ref_cnt_q;
	logic [2:0] ref_tri_q;
	logic ref_tick;
	logic [1:0] tap_q;

	assign ref_tick = pin_edge[2] && (ref_cnt_q <= FND_REF_RATIO_W'(1));

	always_ff @(posedge mclk) begin
		if (rst || frac_cfg_q.power_down) begin
			ref_cnt_q <= ref_cfg_q[FND_REF_RATIO_LSB +: FND_REF_RATIO_W];
			ref_tri_q <= 3'h0;
		end else if (pin_edge[2]) begin
			ref_cnt_q <= ref_tick ? ref_cfg_q[FND_REF_RATIO_LSB +: FND_REF_RATIO_W] : ref_cnt_q - 1'b1;
			if (ref_tick) begin
				ref_tri_q <= ref_tri_q + 3'h1;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			tap_q <= 2'h0;
		end else begin
			tap_q[0] <= tap_hit(ref_cfg_q[FND_MTAP_LSB +: 3], ref_tri_q, ref_tick);
			tap_q[1] <= tap_hit(ref_cfg_q[FND_ATAP_LSB +: 3], ref_tri_q, ref_tick);
		end
	end

	// Phase/frequency detectors: index 0 main, 1 aux
	logic [1:0] div_pulse;
	logic [1:0] pfd_up_q, pfd_dn_q;
	logic [3:0] bl_cnt_q [2];

	assign div_pulse = {aux_pulse_q, fb_pulse_q};

	for (genvar i = 0; i < 2; i++) begin : g_pfd
		always_ff @(posedge mclk) begin
			if (rst || frac_cfg_q.power_down) begin
				pfd_up_q[i] <= 1'b0;
				pfd_dn_q[i] <= 1'b0;
				bl_cnt_q[i] <= 4'h0;
			end else if (pfd_up_q[i] && pfd_dn_q[i]) begin
				if (bl_cnt_q[i] == 4'(BACKLASH_CYC_P - 1)) begin
					pfd_up_q[i] <= 1'b0;
					pfd_dn_q[i] <= 1'b0;
					bl_cnt_q[i] <= 4'h0;
				end else begin
					bl_cnt_q[i] <= bl_cnt_q[i] + 4'h1;
				end
			end else begin
				pfd_up_q[i] <= pfd_up_q[i] | tap_q[i];
				pfd_dn_q[i] <= pfd_dn_q[i] | div_pulse[i];
			end
		end
	end

	// Registered outputs
	always_ff @(posedge mclk) begin
		if (rst) begin
			main_prop_pump <= '0;
			main_int_pump <= '0;
			aux_pump <= '0;
			pump_gain <= 2'h0;
			frac_acc <= 3'h0;
			main_fb_pulse <= 1'b0;
		end else begin
			main_prop_pump <= {pfd_up_q[0], pfd_dn_q[0]};
			main_int_pump <= frac_cfg_q.pump_gain_bit1 ? 2'h0 : {pfd_up_q[0], pfd_dn_q[0]};
			aux_pump <= {pfd_up_q[1], pfd_dn_q[1]};
			pump_gain <= {frac_cfg_q.pump_gain_bit1, frac_cfg_q.pump_gain_bit0};
			frac_acc <= acc_q;
			main_fb_pulse <= fb_pulse_q;
		end
	end

	// Register read
	assign ar_hit = 1'b1;
	always_comb begin
		rd_d = 32'h0;
		unique case (s_axi_araddr)
			FND_MAIN_OFS: rd_d = {16'h0000, main_ratio_q};
			FND_FRAC_OFS: rd_d = {25'h0, frac_cfg_q};
			FND_AUX_OFS: rd_d = {16'h0000, aux_cfg_q};
			FND_REF_OFS: rd_d = {16'h0000, ref_cfg_q};
			FND_STAT_OFS: rd_d = {22'h0, pfd_dn_q[1], pfd_up_q[1], pfd_dn_q[0], pfd_up_q[0], ref_tri_q, acc_q};
			default: rd_d = 32'h0;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= FND_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready && ar_hit) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_d;
			s_axi_rresp <= (s_axi_araddr > FND_STAT_OFS || s_axi_araddr[1:0] != 2'h0) ? FND_RESP_SLVERR : FND_RESP_OKAY;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// Checks
	a_acc_in_range: assert property (@(posedge mclk) disable iff (rst) acc_q < modulus || $changed(modulus))
		else $error("accumulator beyond modulus");
	a_acc_advance: assert property (@(posedge mclk) disable iff (rst || frac_cfg_q.power_down)
		main_end |=> acc_q == $past(acc_d))
		else $error("accumulator did not advance at cycle end");
	a_cycle_stretch: assert property (@(posedge mclk) disable iff (rst || frac_cfg_q.power_down)
		main_end && acc_ovf |=> main_cnt_q == ratio_of($past(main_ratio_q)) + 17'h00001)
		else $error("overflow did not lengthen cycle");
	a_fb_one_pulse: assert property (@(posedge mclk) disable iff (rst) fb_pulse_q |=> !fb_pulse_q)
		else $error("feedback pulse longer than one cycle");
	a_ratio_sync: assert property (@(posedge mclk) disable iff (rst || frac_cfg_q.power_down)
		$changed(n_cur_q) |-> $past(main_end))
		else $error("ratio changed mid cycle");
	a_int_pump_off: assert property (@(posedge mclk) disable iff (rst)
		$past(frac_cfg_q.pump_gain_bit1) |-> main_int_pump == 2'h0)
		else $error("integral pump active while disabled");
	a_backlash_hold: assert property (@(posedge mclk) disable iff (rst || frac_cfg_q.power_down)
		pfd_up_q[0] && pfd_dn_q[0] && bl_cnt_q[0] != 4'(BACKLASH_CYC_P - 1) |=>
		pfd_up_q[0] && pfd_dn_q[0])
		else $error("backlash window cut short");
	a_restart_sync: assert property (@(posedge mclk) disable iff (rst)
		pd_last_q && !frac_cfg_q.power_down |-> ref_tri_q == 3'h0 && acc_q == 3'h0 &&
		main_cnt_q == ratio_of(main_ratio_q))
		else $error("dividers not restarted together");
	a_mod_select: assert property (@(posedge mclk) disable iff (rst)
		frac_cfg_q.fraction_modulus_select |-> modulus == 4'h5)
		else $error("modulus select decoded wrongly");
endmodule

//--- tb/fnd_sig_model.sv
// Free-running square-wave sources for the VCO, auxiliary and reference inputs
`timescale 1ns/1ps
module fnd_sig_model #(
	parameter int VCO_HALF = 2,
	parameter int AUX_HALF = 2,
	parameter int REF_HALF = 3
) (
	// Clock
	input wire logic mclk,
	// Oscillator outputs
	output logic vco_input,
	output logic aux_input,
	output logic ref_input
);
	int vc = 0;
	int ac = 0;
	int rc = 0;
	initial begin
		vco_input = 1'h0;
		aux_input = 1'h0;
		ref_input = 1'h0;
	end
	// Each level lasts at least two mclk so no edge is lost in the synchronisers
	always @(posedge mclk) begin
		vc = (vc + 1) % VCO_HALF;
		ac = (ac + 1) % AUX_HALF;
		rc = (rc + 1) % REF_HALF;
		if (vc == 0) vco_input <= ~vco_input;
		if (ac == 0) aux_input <= ~aux_input;
		if (rc == 0) ref_input <= ~ref_input;
	end
endmodule

//--- tb/fnd_core_tb.sv
// Self-checking bench of the fractional-N divider core
`timescale 1ns/1ps
module fnd_core_tb import fnd_pkg::*;;
	typedef struct packed {logic mod5; logic [2:0] inc; logic [15:0] n;} fnd_row_t;
	localparam int BL = 2;
	fnd_row_t rows [3] = '{'{1'h0, 3'h3, 16'h0200}, '{1'h1, 3'h4, 16'h0200}, '{1'h1, 3'h0, 16'h0203}};
	logic mclk = 1'h0;
	logic rst = 1'h1;
	logic vco_input, aux_input, ref_input;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, main_fb_pulse;
	logic [1:0] s_axi_bresp, s_axi_rresp, pump_gain;
	fnd_pump_t main_prop_pump, main_int_pump, aux_pump;
	logic [2:0] frac_acc;
	logic mon_en = 1'h0, pd_on = 1'h0, prev_mu = 1'h0, prev_au = 1'h0;
	int fails = 0, total_checks = 0, cyc = 0, acc_dly = 0, wd = 0, runlen = 0;
	int up_rises = 0, aux_rises = 0, int_seen = 0, pd_bad = 0, q = 0, s = 0, n = 0;
	int per_q[$];
	logic [2:0] acc_q[$];

	always #12.5 mclk = ~mclk;

	fnd_core #(.BACKLASH_CYC_P(BL)) u_dut (.mclk(mclk), .rst(rst), .vco_input(vco_input), .aux_input(aux_input),
		.ref_input(ref_input), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
		.main_prop_pump(main_prop_pump), .main_int_pump(main_int_pump), .aux_pump(aux_pump),
		.pump_gain(pump_gain), .frac_acc(frac_acc), .main_fb_pulse(main_fb_pulse));
	fnd_sig_model u_sig (.mclk(mclk), .vco_input(vco_input), .aux_input(aux_input), .ref_input(ref_input));

	task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			fails++;
			$display("mismatch %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic aw_ok;
		logic w_ok;
		aw_ok = 1'h0;
		w_ok = 1'h0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		while (!(aw_ok && w_ok)) begin
			@(posedge mclk);
			if (!aw_ok && s_axi_awready === 1'h1) begin
				aw_ok = 1'h1;
				s_axi_awvalid <= 1'h0;
			end
			if (!w_ok && s_axi_wready === 1'h1) begin
				w_ok = 1'h1;
				s_axi_wvalid <= 1'h0;
			end
		end
		do @(posedge mclk); while (s_axi_bvalid !== 1'h1);
		check("bresp", er, s_axi_bresp);
		s_axi_bready <= 1'h0;
		@(posedge mclk);
	endtask

	task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do @(posedge mclk); while (s_axi_arready !== 1'h1);
		s_axi_arvalid <= 1'h0;
		do @(posedge mclk); while (s_axi_rvalid !== 1'h1);
		check("rdata", ed, s_axi_rdata);
		check("rresp", er, s_axi_rresp);
		s_axi_rready <= 1'h0;
		@(posedge mclk);
	endtask

	task automatic wait_pulses(input int k);
		while (per_q.size() < k) @(posedge mclk);
	endtask

	// Watchdog, period log and pump watchers
	always @(posedge mclk) begin
		wd++;
		if (wd == 95000) begin
			fails++;
			report_and_stop();
		end
		cyc++;
		if (main_fb_pulse === 1'h1) begin
			per_q.push_back(cyc);
			cyc = 0;
			acc_dly = 4;
		end else if (acc_dly > 0) begin
			acc_dly--;
			if (acc_dly == 0) acc_q.push_back(frac_acc);
		end
		if (!mon_en) runlen = 0;
		else if (main_prop_pump.up & main_prop_pump.dn) runlen++;
		else if (runlen > 0) begin
			check("backlash run", BL, runlen);
			runlen = 0;
		end
		if (main_int_pump !== 2'h0) int_seen++;
		if (main_prop_pump.up === 1'h1 && !prev_mu) up_rises++;
		if (aux_pump.up === 1'h1 && !prev_au) aux_rises++;
		prev_mu = main_prop_pump.up;
		prev_au = aux_pump.up;
		if (pd_on && {main_prop_pump, main_int_pump, aux_pump, main_fb_pulse} !== 7'h0) pd_bad++;
	end

	initial begin
		repeat (4) @(posedge mclk);
		rst <= 1'h0;
		@(posedge mclk);
		axi_rd(FND_MAIN_OFS, {16'h0, FND_MAIN_RST}, FND_RESP_OKAY);
		axi_rd(FND_FRAC_OFS, 32'h0, FND_RESP_OKAY);
		axi_rd(FND_AUX_OFS, {16'h0, FND_AUX_RST}, FND_RESP_OKAY);
		axi_rd(FND_REF_OFS, {16'h0, FND_REF_RST}, FND_RESP_OKAY);
		axi_rd(8'h14, 32'h0, FND_RESP_SLVERR);
		axi_rd(8'h02, 32'h0, FND_RESP_SLVERR);
		axi_wr(FND_STAT_OFS, 32'h1, FND_RESP_SLVERR);
		axi_wr(8'h20, 32'h1, FND_RESP_SLVERR);
		$display("test registers done");
		mon_en = 1'h1;
		foreach (rows[i]) begin
			q = rows[i].mod5 ? 5 : 8;
			axi_wr(FND_MAIN_OFS, {16'h0, rows[i].n}, FND_RESP_OKAY);
			axi_wr(FND_FRAC_OFS, {28'h0, rows[i].mod5, rows[i].inc}, FND_RESP_OKAY);
			per_q.delete();
			wait_pulses(2);
			per_q.delete();
			acc_q.delete();
			wait_pulses(q);
			repeat (6) @(posedge mclk);
			s = 0;
			for (int k = 0; k < q; k++) s += per_q[k];
			check("fraction sum", (q * rows[i].n + rows[i].inc) * 4, s);
			for (int k = 1; k < acc_q.size(); k++) begin
				check("acc step", (acc_q[k - 1] + rows[i].inc) % q, acc_q[k]);
			end
			$display("test fraction row %0d done", i);
		end
		per_q.delete();
		wait_pulses(1);
		repeat (300) @(posedge mclk);
		axi_wr(FND_MAIN_OFS, 32'h0000_0258, FND_RESP_OKAY);
		wait_pulses(3);
		check("period at load", 515 * 4, per_q[1]);
		check("period after load", 600 * 4, per_q[2]);
		$display("test ratio reload done");
		for (int g = 0; g < 4; g++) begin
			axi_wr(FND_FRAC_OFS, 32'(g) << 4, FND_RESP_OKAY);
			repeat (4) @(posedge mclk);
			int_seen = 0;
			repeat (100) @(posedge mclk);
			check("pump gain", g, pump_gain);
			check("integral active", g < 2, int_seen > 0);
		end
		$display("test pump gain done");
		axi_wr(FND_REF_OFS, 32'h0000_fc04, FND_RESP_OKAY);
		repeat (3000) @(posedge mclk);
		up_rises = 0;
		aux_rises = 0;
		repeat (3000) @(posedge mclk);
		check("idle main up", 0, up_rises);
		check("idle aux up", 0, aux_rises);
		axi_wr(FND_REF_OFS, 32'h0000_0004, FND_RESP_OKAY);
		repeat (600) @(posedge mclk);
		check("active main up", 1, up_rises > 0);
		check("active aux up", 1, aux_rises > 0);
		$display("test taps done");
		mon_en = 1'h0;
		axi_wr(FND_FRAC_OFS, 32'h0000_0040, FND_RESP_OKAY);
		repeat (4) @(posedge mclk);
		pd_on = 1'h1;
		repeat (3000) @(posedge mclk);
		pd_on = 1'h0;
		check("quiet in power-down", 0, pd_bad);
		check("acc in power-down", 0, frac_acc);
		axi_wr(FND_FRAC_OFS, 32'h0, FND_RESP_OKAY);
		per_q.delete();
		n = 0;
		while (per_q.size() < 1) begin
			@(posedge mclk);
			n++;
		end
		check("restart delay", 1, n >= 2390 && n <= 2415);
		$display("test power-down done");
		report_and_stop();
	end
endmodule
